// *** ebcmc_pkg.sv ***
// Package with register map, field layout and encodings of the bus unit.
package ebcmc_pkg;

    localparam logic [11:0] OFF_MODE = 12'h000;
    localparam logic [11:0] OFF_REG0 = 12'h010;
    localparam logic [11:0] OFF_REG1 = 12'h014;
    localparam logic [11:0] OFF_TIM0 = 12'h040;
    localparam logic [11:0] OFF_TIM1 = 12'h044;
    localparam logic [3:0] SEL_ALL = 4'hF;

    localparam int MODE_SEL_BIT = 0;
    localparam int MODE_STR_LSB = 1;
    localparam int REG_TAG_LSB = 24;
    localparam int REG_START_LSB = 16;
    localparam int REG_SIZE_LSB = 0;
    localparam int TIM_CSR_LSB = 30;
    localparam int TIM_WRR_LSB = 27;
    localparam int TIM_RDR_LSB = 24;
    localparam int TIM_ALEW_LSB = 20;
    localparam int TIM_WRS_LSB = 18;
    localparam int TIM_RDS_LSB = 16;
    localparam int TIM_CSIW_LSB = 8;

    localparam logic [31:0] TIM_MASK = 32'hFF3F_1F8F;
    localparam logic [31:0] TIM_RESET = 32'h4911_0200;
    localparam logic [7:0] REG_TAG_RESET = 8'h00;
    localparam logic [7:0] SIZE_MAX_CODE = 8'h08;
    localparam logic [8:0] SIZE_FULL_UNITS = 9'h100;

    localparam logic [1:0] STR_NONE = 2'h0;
    localparam logic [1:0] STR_DOUBLE = 2'h1;
    localparam logic [1:0] STR_QUAD = 2'h2;
    localparam logic [1:0] SHIFT_ONE = 2'h1;
    localparam logic [1:0] SHIFT_TWO = 2'h2;
    localparam logic [1:0] SHIFT_NONE = 2'h0;

    localparam logic [6:0] WIN_TOP_BITS = 7'h30;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ALE = 6'h02,
        ST_SETUP = 6'h04,
        ST_STROBE = 6'h08,
        ST_RECOV = 6'h10,
        ST_END = 6'h20
    } ebcmc_state_t;

    // Two-bit cycle code: none, one, two or four cycles.
    function automatic logic [7:0] ebcmc_cyc2(input logic [1:0] code);
        ebcmc_cyc2 = (code == 2'h3) ? 8'h04 : {6'h00, code};
    endfunction : ebcmc_cyc2

    // Three-bit cycle code: none to six cycles, then eight.
    function automatic logic [7:0] ebcmc_cyc3(input logic [2:0] code);
        ebcmc_cyc3 = (code == 3'h7) ? 8'h08 : {5'h00, code};
    endfunction : ebcmc_cyc3

endpackage : ebcmc_pkg

// *** ebcmc_region.sv ***
// Chip-select region decoder with window check and select priority.
`timescale 1ns/100ps
module ebcmc_region (
    input wire logic [31:0] addr,
    input wire logic [1:0][7:0] start,
    input wire logic [1:0][7:0] size_code,
    output logic in_window,
    output logic [1:0] hit
);
    logic [1:0] match;

    assign in_window = (addr[31:25] == ebcmc_pkg::WIN_TOP_BITS);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic [8:0] offset;
            logic [8:0] span;
            assign offset = {1'b0, addr[23:16]} - {1'b0, start[g]};
            assign span = ebcmc_pkg::SIZE_FULL_UNITS >> size_code[g][3:0];
            // A region matches at or above its start and below start+size.
            assign match[g] = (addr[23:16] >= start[g]) && (offset < span)
                && (size_code[g] <= ebcmc_pkg::SIZE_MAX_CODE);
        end
    endgenerate

    // Select zero wins where both regions cover the address.
    assign hit = match[0] ? 2'b01 : (match[1] ? 2'b10 : 2'b00);

endmodule : ebcmc_region

// *** ebcmc_top.sv ***
// Bus mode, region decode and bus cycle sequencing of the external bus unit.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
module ebcmc_top (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic ACC_REQ,
    input wire logic ACC_WE,
    input wire logic [31:0] ACC_ADDR,
    input wire logic [15:0] ACC_WDATA,
    output logic [15:0] ACC_RDATA,
    output logic ACC_DONE,
    output logic ACC_FAULT,
    output logic BUS_SEPARATE,
    output logic [23:0] EXT_ADDR,
    output logic [15:0] EXT_AD_OUT,
    output logic EXT_AD_OE_N,
    input wire logic [15:0] EXT_AD_IN,
    output logic EXT_ALE,
    output logic EXT_RD_N,
    output logic EXT_WR_N,
    output logic EXT_CS0_N,
    output logic EXT_CS1_N
);
    typedef struct packed {
        logic mode_sep;
        logic [1:0] mode_str;
        logic [1:0][7:0] reg_tag;
        logic [1:0][7:0] reg_start;
        logic [1:0][7:0] reg_size;
        logic [1:0][31:0] tim;
        logic wb_ack;
        logic [31:0] wb_dat;
        ebcmc_pkg::ebcmc_state_t st;
        logic [7:0] cnt;
        logic lat_we;
        logic lat_sep;
        logic [7:0] len_set;
        logic [7:0] len_str;
        logic [7:0] len_rec;
        logic [15:0] lat_wdata;
        logic [23:0] ext_addr;
        logic [15:0] ad_out;
        logic ad_oe_n;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic [1:0] cs_n;
        logic done;
        logic fault;
        logic [15:0] rdata;
    } ebcmc_regs_t;

    ebcmc_regs_t s_r;
    ebcmc_regs_t s_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic wb_req;
    logic [31:0] rd_val;
    logic in_window;
    logic [1:0] hit;
    logic ch;
    logic [1:0] k;
    logic [31:0] tsel;
    logic [7:0] len_ale;
    logic [7:0] len_set;
    logic [7:0] len_str;
    logic [7:0] len_rec;
    logic [7:0] rec_rw;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    ebcmc_region ebcmc_region_i (
        .addr(ACC_ADDR),
        .start(s_r.reg_start),
        .size_code(s_r.reg_size),
        .in_window(in_window),
        .hit(hit)
    );

    assign wb_req = WB_CYC_I & WB_STB_I;

    // Register read view; reserved bits are forced to zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        case (WB_ADR_I)
            ebcmc_pkg::OFF_MODE: begin
                rd_val[ebcmc_pkg::MODE_SEL_BIT] = s_r.mode_sep;
                rd_val[ebcmc_pkg::MODE_STR_LSB +: 2] = s_r.mode_str;
            end
            ebcmc_pkg::OFF_REG0, ebcmc_pkg::OFF_REG1: begin
                rd_val[ebcmc_pkg::REG_TAG_LSB +: 8] = s_r.reg_tag[WB_ADR_I[2]];
                rd_val[ebcmc_pkg::REG_START_LSB +: 8] =
                    s_r.reg_start[WB_ADR_I[2]];
                rd_val[ebcmc_pkg::REG_SIZE_LSB +: 8] =
                    s_r.reg_size[WB_ADR_I[2]];
            end
            ebcmc_pkg::OFF_TIM0, ebcmc_pkg::OFF_TIM1: begin
                rd_val = s_r.tim[WB_ADR_I[2]] & ebcmc_pkg::TIM_MASK;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // Phase lengths of the chosen select, scaled by the stretch factor.
    always_comb begin
        ch = hit[1];
        tsel = s_r.tim[ch];
        case (s_r.mode_str)
            ebcmc_pkg::STR_DOUBLE: k = ebcmc_pkg::SHIFT_ONE;
            ebcmc_pkg::STR_QUAD: k = ebcmc_pkg::SHIFT_TWO;
            default: k = ebcmc_pkg::SHIFT_NONE;
        endcase
        rec_rw = ACC_WE
            ? ebcmc_pkg::ebcmc_cyc3(tsel[ebcmc_pkg::TIM_WRR_LSB +: 3])
            : ebcmc_pkg::ebcmc_cyc3(tsel[ebcmc_pkg::TIM_RDR_LSB +: 3]);
        len_ale = 8'((8'h01 + ebcmc_pkg::ebcmc_cyc2(
            tsel[ebcmc_pkg::TIM_ALEW_LSB +: 2])) << k);
        len_set = 8'((ACC_WE
            ? ebcmc_pkg::ebcmc_cyc2(tsel[ebcmc_pkg::TIM_WRS_LSB +: 2])
            : ebcmc_pkg::ebcmc_cyc2(tsel[ebcmc_pkg::TIM_RDS_LSB +: 2])) << k);
        len_str = 8'((8'h01 + {3'h0, tsel[ebcmc_pkg::TIM_CSIW_LSB +: 5]})
            << k);
        len_rec = 8'((ebcmc_pkg::ebcmc_cyc2(tsel[ebcmc_pkg::TIM_CSR_LSB +: 2])
            + rec_rw) << k);
    end

    always_comb begin
        logic go_set;
        logic go_str;
        go_set = 1'b0;
        go_str = 1'b0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.fault = 1'b0;
        s_nxt.wb_ack = wb_req & ~s_r.wb_ack;
        if (wb_req && !s_r.wb_ack) begin
            s_nxt.wb_dat = rd_val;
            // Partial-word writes are dropped.
            if (WB_WE_I && WB_SEL_I == ebcmc_pkg::SEL_ALL) begin
                case (WB_ADR_I)
                    ebcmc_pkg::OFF_MODE: begin
                        s_nxt.mode_sep = WB_DAT_I[ebcmc_pkg::MODE_SEL_BIT];
                        s_nxt.mode_str =
                            WB_DAT_I[ebcmc_pkg::MODE_STR_LSB +: 2];
                    end
                    ebcmc_pkg::OFF_REG0, ebcmc_pkg::OFF_REG1: begin
                        s_nxt.reg_tag[WB_ADR_I[2]] =
                            WB_DAT_I[ebcmc_pkg::REG_TAG_LSB +: 8];
                        s_nxt.reg_start[WB_ADR_I[2]] =
                            WB_DAT_I[ebcmc_pkg::REG_START_LSB +: 8];
                        s_nxt.reg_size[WB_ADR_I[2]] =
                            WB_DAT_I[ebcmc_pkg::REG_SIZE_LSB +: 8];
                    end
                    ebcmc_pkg::OFF_TIM0, ebcmc_pkg::OFF_TIM1: begin
                        s_nxt.tim[WB_ADR_I[2]] =
                            WB_DAT_I & ebcmc_pkg::TIM_MASK;
                    end
                    default: begin
                        s_nxt.wb_dat = 32'h0000_0000;
                    end
                endcase
            end
        end
        case (s_r.st)
            ebcmc_pkg::ST_IDLE: begin
                // Address pins keep the last external address.
                s_nxt.ad_oe_n = 1'b1;
                if (ACC_REQ) begin
                    if (!in_window) begin
                        s_nxt.fault = 1'b1;
                        s_nxt.st = ebcmc_pkg::ST_END;
                    end else begin
                        // Mode is taken once per access.
                        s_nxt.lat_sep = s_r.mode_sep;
                        s_nxt.lat_we = ACC_WE;
                        s_nxt.lat_wdata = ACC_WDATA;
                        s_nxt.len_set = len_set;
                        s_nxt.len_str = len_str;
                        s_nxt.len_rec = len_rec;
                        s_nxt.ext_addr = ACC_ADDR[23:0];
                        s_nxt.cs_n = ~hit;
                        if (!s_r.mode_sep) begin
                            s_nxt.st = ebcmc_pkg::ST_ALE;
                            s_nxt.cnt = len_ale - 8'h01;
                            s_nxt.ale = 1'b1;
                            s_nxt.ad_out = ACC_ADDR[15:0];
                            s_nxt.ad_oe_n = 1'b0;
                        end else if (len_set != 8'h00) begin
                            s_nxt.lat_sep = 1'b1;
                            s_nxt.st = ebcmc_pkg::ST_SETUP;
                            s_nxt.cnt = len_set - 8'h01;
                            s_nxt.ad_out = ACC_WDATA;
                            s_nxt.ad_oe_n = ~ACC_WE;
                        end else begin
                            s_nxt.lat_wdata = ACC_WDATA;
                            go_str = 1'b1;
                        end
                    end
                end
            end
            ebcmc_pkg::ST_ALE: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.ale = 1'b0;
                    go_set = (s_r.len_set != 8'h00);
                    go_str = (s_r.len_set == 8'h00);
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            ebcmc_pkg::ST_SETUP: begin
                if (s_r.cnt == 8'h00) begin
                    go_str = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            ebcmc_pkg::ST_STROBE: begin
                if (s_r.cnt == 8'h00) begin
                    if (!s_r.lat_we) begin
                        s_nxt.rdata = EXT_AD_IN;
                    end
                    s_nxt.rd_n = 1'b1;
                    s_nxt.wr_n = 1'b1;
                    s_nxt.cs_n = 2'b11;
                    s_nxt.ad_oe_n = 1'b1;
                    if (s_r.len_rec != 8'h00) begin
                        s_nxt.st = ebcmc_pkg::ST_RECOV;
                        s_nxt.cnt = s_r.len_rec - 8'h01;
                    end else begin
                        s_nxt.st = ebcmc_pkg::ST_END;
                        s_nxt.done = 1'b1;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            ebcmc_pkg::ST_RECOV: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.st = ebcmc_pkg::ST_END;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - 8'h01;
                end
            end
            ebcmc_pkg::ST_END: begin
                if (!ACC_REQ) begin
                    s_nxt.st = ebcmc_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ebcmc_pkg::ST_IDLE;
            end
        endcase
        if (go_set) begin
            s_nxt.st = ebcmc_pkg::ST_SETUP;
            s_nxt.cnt = s_r.len_set - 8'h01;
            s_nxt.ad_out = s_r.lat_wdata;
            s_nxt.ad_oe_n = ~s_r.lat_we;
        end
        if (go_str) begin
            s_nxt.st = ebcmc_pkg::ST_STROBE;
            s_nxt.cnt = (s_r.st == ebcmc_pkg::ST_IDLE) ? len_str - 8'h01
                : s_r.len_str - 8'h01;
            s_nxt.ad_out = s_nxt.lat_wdata;
            s_nxt.ad_oe_n = ~s_nxt.lat_we;
            s_nxt.rd_n = s_nxt.lat_we;
            s_nxt.wr_n = ~s_nxt.lat_we;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.reg_tag <= {ebcmc_pkg::REG_TAG_RESET,
                ebcmc_pkg::REG_TAG_RESET};
            s_r.tim <= {ebcmc_pkg::TIM_RESET, ebcmc_pkg::TIM_RESET};
            s_r.st <= ebcmc_pkg::ST_IDLE;
            s_r.ad_oe_n <= 1'b1;
            s_r.rd_n <= 1'b1;
            s_r.wr_n <= 1'b1;
            s_r.cs_n <= 2'b11;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign WB_DAT_O = s_r.wb_dat;
    assign WB_ACK_O = s_r.wb_ack;
    assign ACC_RDATA = s_r.rdata;
    assign ACC_DONE = s_r.done;
    assign ACC_FAULT = s_r.fault;
    assign BUS_SEPARATE = s_r.mode_sep;
    assign EXT_ADDR = s_r.ext_addr;
    assign EXT_AD_OUT = s_r.ad_out;
    assign EXT_AD_OE_N = s_r.ad_oe_n;
    assign EXT_ALE = s_r.ale;
    assign EXT_RD_N = s_r.rd_n;
    assign EXT_WR_N = s_r.wr_n;
    assign EXT_CS0_N = s_r.cs_n[0];
    assign EXT_CS1_N = s_r.cs_n[1];

    // Length of the read strobe, seen by the strobe checks only.
    logic [7:0] rd_low_cnt;
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_low_cnt <= 8'h00;
        end else begin
            rd_low_cnt <= EXT_RD_N ? 8'h00 : rd_low_cnt + 8'h01;
        end
    end

    property p_cs_excl;
        @(posedge CORE_CLK) disable iff (!rst_n)
        !(!EXT_CS0_N && !EXT_CS1_N);
    endproperty
    a_cs_excl: assert property (p_cs_excl)
        else $error("Both chip selects asserted.");

    property p_fault;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (s_r.st == ebcmc_pkg::ST_IDLE && ACC_REQ && ACC_ADDR[31:25] !=
            ebcmc_pkg::WIN_TOP_BITS) |=> ACC_FAULT && EXT_CS0_N && EXT_CS1_N
            ##1 !ACC_FAULT;
    endproperty
    a_fault: assert property (p_fault)
        else $error("Out-of-window access did not fault.");

    property p_idle_hold;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (s_r.st == ebcmc_pkg::ST_IDLE && $past(s_r.st) == ebcmc_pkg::ST_IDLE)
            |-> $stable(EXT_ADDR) && EXT_AD_OE_N;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("Idle bus did not hold address or float data.");

    property p_resv_read;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (WB_ACK_O && !WB_WE_I && (WB_ADR_I == ebcmc_pkg::OFF_REG0 ||
            WB_ADR_I == ebcmc_pkg::OFF_REG1)) |-> WB_DAT_O[15:8] == 8'h00;
    endproperty
    a_resv_read: assert property (p_resv_read)
        else $error("Reserved region bits read nonzero.");

    property p_no_ale_sep;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (s_r.st == ebcmc_pkg::ST_IDLE && ACC_REQ && s_r.mode_sep)
            |=> !EXT_ALE [*2];
    endproperty
    a_no_ale_sep: assert property (p_no_ale_sep)
        else $error("Latch strobe in separate bus mode.");

    property p_rd_len;
        @(posedge CORE_CLK) disable iff (!rst_n)
        $rose(EXT_RD_N) |-> rd_low_cnt == s_r.len_str;
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("Read strobe length wrong.");

    property p_bad_size;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (s_r.st == ebcmc_pkg::ST_IDLE && ACC_REQ &&
            s_r.reg_size[0] > ebcmc_pkg::SIZE_MAX_CODE &&
            s_r.reg_size[1] > ebcmc_pkg::SIZE_MAX_CODE)
            |=> EXT_CS0_N && EXT_CS1_N;
    endproperty
    a_bad_size: assert property (p_bad_size)
        else $error("Select driven with barred size code.");

    property p_below_start;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (s_r.st == ebcmc_pkg::ST_IDLE && ACC_REQ &&
            ACC_ADDR[23:16] < s_r.reg_start[0] &&
            ACC_ADDR[23:16] < s_r.reg_start[1])
            |=> EXT_CS0_N && EXT_CS1_N;
    endproperty
    a_below_start: assert property (p_below_start)
        else $error("Select driven below region start.");

endmodule : ebcmc_top

// *** ebcmc_ext_mem.sv ***
// Model of an external memory device on the address and data pins.
`timescale 1ns/100ps
module ebcmc_ext_mem (
    input wire logic clk,
    input wire logic sep,
    input wire logic ale,
    input wire logic [23:0] addr,
    input wire logic [15:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cs_n,
    output logic [15:0] ad_in,
    output logic [15:0] wr_seen
);
    logic [15:0] last_r = 16'h0000;
    logic [15:0] low_r = 16'h0000;
    logic [15:0] low;
    logic [15:0] seen_r = 16'h0000;
    assign wr_seen = seen_r;
    // The low address comes from the latch in multiplexed mode.
    assign low = sep ? addr[15:0] : low_r;
    // Released pins show a pattern that changes every cycle.
    assign ad_in = (!cs_n && !rd_n) ? (low ^ 16'h5A3C) : ~last_r;
    always @(posedge clk) begin
        last_r <= ad_in;
        if (ale) begin
            low_r <= ad_out;
        end
        if (!cs_n && !wr_n && !ad_oe_n) begin
            seen_r <= ad_out;
        end
    end
endmodule : ebcmc_ext_mem

// *** test_ext_bus_cs_mode_config.sv ***
// Self-checking bench for the bus mode and chip-select decode unit.
`timescale 1ns/100ps
module test_ext_bus_cs_mode_config;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic req = 1'b0;
    logic awe = 1'b0;
    logic [31:0] aadr = 32'h0000_0000;
    logic [15:0] awd = 16'h0000;
    logic [31:0] rdat, got;
    logic [23:0] ext_addr;
    logic [15:0] ard, ad_out, ad_in, wr_seen;
    logic ack, done, fault, sep, ad_oe_n, ale, rd_n, wr_n, cs0_n, cs1_n;
    logic seen0, seen1, seen_ale, fl;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 51921;
    int an;
    always #50 clk = ~clk;
    ebcmc_top ebcmc_top_i (
        .CORE_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .ACC_REQ(req), .ACC_WE(awe),
        .ACC_ADDR(aadr), .ACC_WDATA(awd), .ACC_RDATA(ard), .ACC_DONE(done),
        .ACC_FAULT(fault), .BUS_SEPARATE(sep), .EXT_ADDR(ext_addr),
        .EXT_AD_OUT(ad_out), .EXT_AD_OE_N(ad_oe_n), .EXT_AD_IN(ad_in),
        .EXT_ALE(ale), .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .EXT_CS0_N(cs0_n),
        .EXT_CS1_N(cs1_n)
    );
    ebcmc_ext_mem ebcmc_ext_mem_i (
        .clk(clk), .sep(sep), .ale(ale), .addr(ext_addr), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs0_n & cs1_n),
        .ad_in(ad_in), .wr_seen(wr_seen)
    );
    task automatic test_done;
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One classic bus cycle; the request holds until ack is sampled.
    task automatic wb(input logic w, input logic [11:0] a,
            input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("wb_ack", 32'h1, {31'h0, ack});
    endtask : wb
    task automatic rdchk(input string nm, input logic [11:0] a,
            input logic [31:0] e);
        wb(1'b0, a, ebcmc_pkg::SEL_ALL, 32'h0000_0000);
        chk(nm, e, got);
    endtask : rdchk
    // One access; counts edges until done or fault and records pins.
    task automatic acc(input logic w, input logic [31:0] a,
            input logic [15:0] d);
        an = 0;
        seen0 = 1'b0;
        seen1 = 1'b0;
        seen_ale = 1'b0;
        @(posedge clk);
        req <= 1'b1;
        awe <= w;
        aadr <= a;
        awd <= d;
        do begin
            @(posedge clk);
            an++;
            seen0 = seen0 | !cs0_n;
            seen1 = seen1 | !cs1_n;
            seen_ale = seen_ale | ale;
        end while (done !== 1'b1 && fault !== 1'b1 && an < 400);
        fl = fault;
        req <= 1'b0;
        @(posedge clk);
    endtask : acc
    function automatic int c2(input logic [1:0] c);
        return (c == 2'h3) ? 4 : int'(c);
    endfunction : c2
    function automatic int c3(input logic [2:0] c);
        return (c == 3'h7) ? 8 : int'(c);
    endfunction : c3
    function automatic logic hit(input logic [7:0] a, input logic [7:0] s,
            input logic [7:0] c);
        return c <= 8'h08 && a >= s && {1'b0, a} < {1'b0, s} + (9'h100 >> c);
    endfunction : hit
    initial begin : main
        logic [7:0] s0, s1, c0, c1, rc;
        logic [1:0] k;
        logic m, w, e0, e1;
        logic [31:0] a, t, tv;
        logic [7:0] win [6] = '{8'h60, 8'h60, 8'h61, 8'h62, 8'h60, 8'h5F};
        int lat;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk("mode_rst", ebcmc_pkg::OFF_MODE, 32'h0);
        rdchk("reg0_rst", ebcmc_pkg::OFF_REG0, 32'h0);
        rdchk("tim1_rst", ebcmc_pkg::OFF_TIM1, ebcmc_pkg::TIM_RESET);
        rdchk("unmapped", 12'h020, 32'h0);
        wb(1'b1, ebcmc_pkg::OFF_MODE, ebcmc_pkg::SEL_ALL, 32'hFFFF_FFFF);
        rdchk("mode_rsv", ebcmc_pkg::OFF_MODE, 32'h7);
        wb(1'b1, ebcmc_pkg::OFF_TIM0, 4'h3, 32'h0);
        rdchk("tim0_part", ebcmc_pkg::OFF_TIM0, ebcmc_pkg::TIM_RESET);
        wb(1'b1, ebcmc_pkg::OFF_TIM0, ebcmc_pkg::SEL_ALL, 32'hFFFF_FFFF);
        rdchk("tim0_mask", ebcmc_pkg::OFF_TIM0, ebcmc_pkg::TIM_MASK);
        for (int i = 0; i < 30; i++) begin
            s0 = 8'($random(seed));
            s1 = s0 + 8'({$random(seed)} % 24);
            c0 = 8'({$random(seed)} % 10);
            c1 = 8'({$random(seed)} % 10);
            k = 2'({$random(seed)} % 3);
            m = 1'($random(seed));
            t = $random(seed);
            tv = $random(seed);
            rc = 8'($random(seed));
            w = tv[10];
            a = {win[i % 6], (i[0] ? s0 : s1) + {4'h0, t[19:16]} - 8'h03,
                t[15:0]};
            wb(1'b1, ebcmc_pkg::OFF_MODE, 4'hF, {29'h0, k, m});
            wb(1'b1, ebcmc_pkg::OFF_REG0, 4'hF,
                {8'h60, s0, t[31:24], c0});
            wb(1'b1, ebcmc_pkg::OFF_REG1, 4'hF,
                {8'h60, s1, t[31:24], c1});
            rdchk("reg1", ebcmc_pkg::OFF_REG1, {8'h60, s1, 8'h0, c1});
            t = {rc, 2'h0, tv[1:0], tv[3:2], tv[5:4], 4'h0, tv[9:6], 8'h00};
            wb(1'b1, ebcmc_pkg::OFF_TIM0, 4'hF, t);
            wb(1'b1, ebcmc_pkg::OFF_TIM1, 4'hF, t);
            acc(w, a, tv[31:16]);
            if (a[31:25] != 7'h30) begin
                chk("fault_lat", 32'h2, 32'(an));
                chk("fault", 32'h2, {30'h0, fl, seen0 | seen1});
            end else begin
                e0 = hit(a[23:16], s0, c0);
                e1 = hit(a[23:16], s1, c1) && !e0;
                lat = 2 + (((m ? 0 : 1 + c2(tv[1:0])) + 1 + int'(tv[9:6])
                    + c2(w ? tv[3:2] : tv[5:4]) + c2(rc[7:6])
                    + c3(w ? rc[5:3] : rc[2:0])) << k);
                chk("done_lat", 32'(lat), 32'(an));
                chk("cs", {30'h0, e0, e1},
                    {30'h0, seen0, seen1});
                chk("ale", {31'h0, !m}, {31'h0, seen_ale});
                chk("sep", {31'h0, m}, {31'h0, sep});
                if (w && (e0 || e1)) chk("wdata", {16'h0, tv[31:16]},
                    {16'h0, wr_seen});
                if (!w && (e0 || e1)) chk("rdata",
                    {16'h0, a[15:0] ^ 16'h5A3C}, {16'h0, ard});
                chk("addr_hold", a[23:0], ext_addr);
                chk("ad_float", 32'h1, {31'h0, ad_oe_n});
            end
        end
        test_done();
    end
endmodule : test_ext_bus_cs_mode_config
